/* common/timer_wave_pkg.sv */
// package of constants for the 8-bit waveform timer
// assumes a 32-bit ahb-lite register bus and a 100 MHz clock

package timer_wave_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_COUNT  = 8'h04;
  localparam logic [7:0] OFF_CMP_A  = 8'h08;
  localparam logic [7:0] OFF_CMP_B  = 8'h0C;
  localparam logic [7:0] OFF_FLAGS  = 8'h10;
  localparam logic [7:0] OFF_PRESC  = 8'h14;
  localparam logic [7:0] OFF_PIN    = 8'h18;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_MODE_LSB  = 0;   // 3 bits wave_mode_sel
  localparam int CTRL_ACT_A_LSB = 4;   // 2 bits out_action_sel_a
  localparam int CTRL_ACT_B_LSB = 6;   // 2 bits out_action_sel_b
  localparam int CTRL_RUN_BIT   = 8;
  localparam int FLAG_WRAP_BIT  = 0;
  localparam int FLAG_MA_BIT    = 1;
  localparam int FLAG_MB_BIT    = 2;
  localparam int PIN_DIR_LSB    = 0;   // 2 bits direction a,b
  localparam int PIN_PORT_LSB   = 2;   // 2 bits plain port level a,b
  localparam int PIN_WAVE_LSB   = 4;   // 2 bits wave levels, read only

  // ---------------------------------------------------------------
  // modes, actions, values
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_NORMAL  = 3'h0;
  localparam logic [2:0] MODE_PC_FF   = 3'h1;
  localparam logic [2:0] MODE_CTC     = 3'h2;
  localparam logic [2:0] MODE_FAST_FF = 3'h3;
  localparam logic [2:0] MODE_PC_A    = 3'h5;
  localparam logic [2:0] MODE_FAST_A  = 3'h7;
  localparam logic [1:0] ACT_NONE     = 2'h0;
  localparam logic [1:0] ACT_TOGGLE   = 2'h1;
  localparam logic [1:0] ACT_CLEAR    = 2'h2;
  localparam logic [1:0] ACT_SET      = 2'h3;
  localparam logic [7:0] CNT_MAX      = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM   = 8'h00;
  localparam logic [15:0] PRESC_RST   = 16'h0000;

endpackage : timer_wave_pkg

/* rtl/timer_waveform_modes.sv */
// 8-bit up/down timer with two compare channels and an ahb-lite slave
// assumes one 100 MHz clock, synchronous inputs, single word transfers
//
// How it works
// - mode zero counts up, wraps max to zero
// - normal mode wrap flag when count becomes zero
// - counting only sets wrap flag, software clears
// - mode two clears count on channel a match
// - mode two compare a unbuffered, may miss
// - mode two sets match flag a at top
// - mode two action one toggles output a
// - mode two wrap flag on max to zero
// - modes three/seven fast pwm, top max/compare a
// - fast pwm counts to top, then clears
// - fast pwm action two/three clear/set polarity
// - fast pwm wrap flag at top
// - fast pwm extreme compares: spike or constant
// - fast pwm action one toggles on match
// - modes one/five phase-correct up-down counting
// - phase-correct holds top one cycle, reverses
// - phase-correct clear up, set down
// - phase-correct wrap flag at bottom
// - phase-correct extreme compares give constant levels
// - phase-correct symmetry transition at bottom
// - action fields never change counting
// - output reaches pin only when direction output
// - pwm modes double buffer compare registers
// - match sets flag on following timer cycle
// - count write wins, blocks next match
// - action zero leaves output register unchanged

`timescale 1ns/100ps
`default_nettype none

module timer_waveform_modes
#(
  parameter int PRESC_W = 16
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic             wave_out_a_o,
  output logic             wave_out_a_oe_o,
  output logic             wave_out_b_o,
  output logic             wave_out_b_oe_o,
  output logic             wrap_flag_o,
  output logic             match_flag_a_o,
  output logic             match_flag_b_o
);

  // ---------------------------------------------------------------
  // checks and state
  // ---------------------------------------------------------------
  if (PRESC_W < 1 || PRESC_W > 16)
  begin : g_bad_presc
    $error("PRESC_W must lie between 1 and 16");
  end

  typedef struct packed {
    logic [7:0]         cnt;
    logic               dn;
    logic [7:0]         buf_a;
    logic [7:0]         buf_b;
    logic [7:0]         ocr_a;
    logic [7:0]         ocr_b;
    logic [2:0]         mode;
    logic [1:0]         act_a;
    logic [1:0]         act_b;
    logic               run;
    logic [PRESC_W-1:0] presc;
    logic [PRESC_W-1:0] pdiv;
    logic               wrap_f;
    logic               match_f_a;
    logic               match_f_b;
    logic               wave_a;
    logic               wave_b;
    logic               up_a;
    logic               up_b;
    logic               blk;
    logic [1:0]         dir;
    logic [1:0]         port;
    logic               dsel;
    logic               dwr;
    logic [7:0]         daddr;
    logic [31:0]        rdata;
  } state_type;

  state_type state_r;
  state_type state_nxt;

  logic       tick;
  logic       fast;
  logic       pc;
  logic       pwm;
  logic [7:0] top;
  logic       at_top;
  logic       mat_a;
  logic       mat_b;
  logic       dnm;
  logic       bot_pc;
  logic       cwr;
  logic       fwr;
  logic       wrap_ev;

  // ---------------------------------------------------------------
  // output level step for one channel
  // ---------------------------------------------------------------
  function automatic logic wave_step(input logic       cur,
                                     input logic [1:0] act,
                                     input logic       m,
                                     input logic       fst,
                                     input logic       phc,
                                     input logic       fbot,
                                     input logic       down,
                                     input logic       sym);
    logic inv;
    inv = (act == timer_wave_pkg::ACT_SET);
    if (act == timer_wave_pkg::ACT_NONE)
      return cur;
    if (act == timer_wave_pkg::ACT_TOGGLE)
      return m ? ~cur : cur;
    if (fst)
    begin
      if (fbot)
        return ~inv;
      return m ? inv : cur;
    end
    if (phc)
    begin
      if (m)
        return down ? ~inv : inv;
      return sym ? inv : cur;
    end
    return m ? inv : cur;
  endfunction : wave_step

  // ---------------------------------------------------------------
  // decode of mode, top and matches
  // ---------------------------------------------------------------
  always_comb
  begin
    fast   = (state_r.mode == timer_wave_pkg::MODE_FAST_FF) ||
             (state_r.mode == timer_wave_pkg::MODE_FAST_A);
    pc     = (state_r.mode == timer_wave_pkg::MODE_PC_FF) ||
             (state_r.mode == timer_wave_pkg::MODE_PC_A);
    pwm    = fast || pc;
    top    = (state_r.mode[2] || state_r.mode == timer_wave_pkg::MODE_CTC) ?
             state_r.ocr_a : timer_wave_pkg::CNT_MAX;
    at_top = (state_r.cnt == top);
    tick   = state_r.run && (state_r.pdiv == state_r.presc);
    mat_a  = (state_r.cnt == state_r.ocr_a) && !state_r.blk;
    mat_b  = (state_r.cnt == state_r.ocr_b) && !state_r.blk;
    // a match at top counts as down-counting, at bottom as up-counting
    dnm    = (state_r.dn && state_r.cnt != timer_wave_pkg::CNT_BOTTOM) || at_top;
    bot_pc = pc && state_r.dn && (state_r.cnt == timer_wave_pkg::CNT_BOTTOM);
    cwr    = state_r.dsel && state_r.dwr && (state_r.daddr == timer_wave_pkg::OFF_COUNT);
    fwr    = state_r.dsel && state_r.dwr && (state_r.daddr == timer_wave_pkg::OFF_FLAGS);
    // wrap event of the current mode, shared by the tick and the flag clear
    wrap_ev = fast ? at_top : (pc ? bot_pc : state_r.cnt == timer_wave_pkg::CNT_MAX);
  end

  // ---------------------------------------------------------------
  // next state: bus, counter, flags, outputs
  // ---------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;

    // prescaler makes the timer tick
    if (!state_r.run || tick)
      state_nxt.pdiv = '0;
    else
      state_nxt.pdiv = state_r.pdiv + 1'b1;

    if (tick)
    begin
      state_nxt.blk = 1'b0;
      // counting depends on the mode only
      unique case (state_r.mode)
        timer_wave_pkg::MODE_CTC:
          state_nxt.cnt = mat_a ? timer_wave_pkg::CNT_BOTTOM
                                : state_r.cnt + 8'h01;
        timer_wave_pkg::MODE_FAST_FF, timer_wave_pkg::MODE_FAST_A:
          state_nxt.cnt = at_top ? timer_wave_pkg::CNT_BOTTOM
                                 : state_r.cnt + 8'h01;
        timer_wave_pkg::MODE_PC_FF, timer_wave_pkg::MODE_PC_A:
          if (!state_r.dn)
          begin
            state_nxt.dn  = at_top;
            state_nxt.cnt = at_top ? state_r.cnt - 8'h01 : state_r.cnt + 8'h01;
          end
          else if (state_r.cnt == timer_wave_pkg::CNT_BOTTOM)
          begin
            state_nxt.dn  = 1'b0;
            state_nxt.cnt = state_r.cnt + 8'h01;
          end
          else
            state_nxt.cnt = state_r.cnt - 8'h01;
        default:
          state_nxt.cnt = state_r.cnt + 8'h01;
      endcase
      if (!pc)
        state_nxt.dn = 1'b0;

      // wrap flag, set here and again in the flag write below
      if (wrap_ev)
        state_nxt.wrap_f = 1'b1;
      // match flags follow the match by one timer cycle
      if (mat_a)
        state_nxt.match_f_a = 1'b1;
      if (mat_b)
        state_nxt.match_f_b = 1'b1;

      // output registers
      state_nxt.wave_a = wave_step(state_r.wave_a, state_r.act_a, mat_a, fast, pc,
                                   fast && at_top, dnm,
                                   bot_pc && !state_r.up_a && state_r.ocr_a != top);
      state_nxt.wave_b = wave_step(state_r.wave_b, state_r.act_b, mat_b, fast, pc,
                                   fast && at_top, dnm,
                                   bot_pc && !state_r.up_b && state_r.ocr_b != top);
      // remember up-counting matches for the symmetry fix at bottom
      if (bot_pc)
      begin
        state_nxt.up_a = 1'b0;
        state_nxt.up_b = 1'b0;
      end
      if (mat_a && !dnm)
        state_nxt.up_a = 1'b1;
      if (mat_b && !dnm)
        state_nxt.up_b = 1'b1;

      // buffered compares load at bottom for fast, at top for dual slope
      if ((fast && at_top) || (pc && at_top && !state_r.dn))
      begin
        state_nxt.ocr_a = state_r.buf_a;
        state_nxt.ocr_b = state_r.buf_b;
      end
    end

    // unbuffered compares outside pwm
    if (!pwm)
    begin
      state_nxt.ocr_a = state_r.buf_a;
      state_nxt.ocr_b = state_r.buf_b;
    end

    // data phase writes
    if (state_r.dsel && state_r.dwr)
    begin
      unique case (state_r.daddr)
        timer_wave_pkg::OFF_CTRL:
        begin
          state_nxt.mode  = hwdata_i[timer_wave_pkg::CTRL_MODE_LSB +: 3];
          state_nxt.act_a = hwdata_i[timer_wave_pkg::CTRL_ACT_A_LSB +: 2];
          state_nxt.act_b = hwdata_i[timer_wave_pkg::CTRL_ACT_B_LSB +: 2];
          state_nxt.run   = hwdata_i[timer_wave_pkg::CTRL_RUN_BIT];
        end
        timer_wave_pkg::OFF_COUNT:
        begin
          state_nxt.cnt = hwdata_i[7:0];
          state_nxt.blk = 1'b1;
        end
        timer_wave_pkg::OFF_CMP_A:
          state_nxt.buf_a = hwdata_i[7:0];
        timer_wave_pkg::OFF_CMP_B:
          state_nxt.buf_b = hwdata_i[7:0];
        timer_wave_pkg::OFF_FLAGS:
        begin
          // write one clears; a set in the same cycle wins
          state_nxt.wrap_f = (state_r.wrap_f & ~hwdata_i[timer_wave_pkg::FLAG_WRAP_BIT])
                             | (tick & wrap_ev);
          state_nxt.match_f_a = (state_r.match_f_a & ~hwdata_i[timer_wave_pkg::FLAG_MA_BIT])
                                | (tick & mat_a);
          state_nxt.match_f_b = (state_r.match_f_b & ~hwdata_i[timer_wave_pkg::FLAG_MB_BIT])
                                | (tick & mat_b);
        end
        timer_wave_pkg::OFF_PRESC:
          state_nxt.presc = hwdata_i[PRESC_W-1:0];
        timer_wave_pkg::OFF_PIN:
        begin
          state_nxt.dir  = hwdata_i[timer_wave_pkg::PIN_DIR_LSB +: 2];
          state_nxt.port = hwdata_i[timer_wave_pkg::PIN_PORT_LSB +: 2];
        end
        default:
          state_nxt.dir = state_r.dir;                                   // unmapped: ignored
      endcase
    end

    // address phase capture and read data
    state_nxt.dsel  = hsel_i && htrans_i[1] && hready_i;
    state_nxt.dwr   = hwrite_i;
    state_nxt.daddr = haddr_i[7:0];
    state_nxt.rdata = 32'h0000_0000;
    if (hsel_i && htrans_i[1] && hready_i && !hwrite_i)
    begin
      unique case (haddr_i[7:0])
        timer_wave_pkg::OFF_CTRL:
          state_nxt.rdata = {23'h00_0000, state_r.run, state_r.act_b, state_r.act_a,
                             1'b0, state_r.mode};
        timer_wave_pkg::OFF_COUNT:
          state_nxt.rdata = {24'h00_0000, state_r.cnt};
        timer_wave_pkg::OFF_CMP_A:
          state_nxt.rdata = {24'h00_0000, state_r.buf_a};
        timer_wave_pkg::OFF_CMP_B:
          state_nxt.rdata = {24'h00_0000, state_r.buf_b};
        timer_wave_pkg::OFF_FLAGS:
          state_nxt.rdata = {29'h0000_0000, state_r.match_f_b, state_r.match_f_a,
                             state_r.wrap_f};
        timer_wave_pkg::OFF_PRESC:
          state_nxt.rdata = 32'(state_r.presc);
        timer_wave_pkg::OFF_PIN:
          state_nxt.rdata = {26'h000_0000, state_r.wave_b, state_r.wave_a,
                             state_r.port, state_r.dir};
        default:
          state_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r       <= '0;
      state_r.presc <= PRESC_W'(timer_wave_pkg::PRESC_RST);
    end
    else
      state_r <= state_nxt;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // the wave level overrides the plain port level when an action is set
  assign wave_out_a_o    = (state_r.act_a != timer_wave_pkg::ACT_NONE) ? state_r.wave_a
                                                                       : state_r.port[0];
  assign wave_out_b_o    = (state_r.act_b != timer_wave_pkg::ACT_NONE) ? state_r.wave_b
                                                                       : state_r.port[1];
  assign wave_out_a_oe_o = state_r.dir[0];
  assign wave_out_b_oe_o = state_r.dir[1];
  assign wrap_flag_o     = state_r.wrap_f;
  assign match_flag_a_o  = state_r.match_f_a;
  assign match_flag_b_o  = state_r.match_f_b;
  assign hrdata_o        = state_r.rdata;
  assign hreadyout_o     = 1'b1;
  assign hresp_o         = 1'b0;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_pc_at_top;
    tick && pc && !state_r.dn && at_top && !cwr;
  endsequence

  sequence s_pc_reversed;
    state_r.dn && state_r.cnt == $past(state_r.cnt) - 8'h01;
  endsequence

  a_normal_wrap: assert property (
    tick && state_r.mode == timer_wave_pkg::MODE_NORMAL &&
    state_r.cnt == timer_wave_pkg::CNT_MAX && !cwr
    |=> state_r.cnt == timer_wave_pkg::CNT_BOTTOM && state_r.wrap_f)
    else $error("normal mode did not wrap with flag");

  a_ctc_clear: assert property (
    tick && state_r.mode == timer_wave_pkg::MODE_CTC && mat_a && !cwr
    |=> state_r.cnt == timer_wave_pkg::CNT_BOTTOM && state_r.match_f_a)
    else $error("ctc did not clear on match");

  a_ctc_toggle: assert property (
    tick && state_r.mode == timer_wave_pkg::MODE_CTC &&
    state_r.act_a == timer_wave_pkg::ACT_TOGGLE && mat_a
    |=> state_r.wave_a != $past(state_r.wave_a))
    else $error("ctc toggle missing");

  a_fast_wrap: assert property (
    tick && fast && at_top && !cwr
    |=> state_r.cnt == timer_wave_pkg::CNT_BOTTOM && state_r.wrap_f)
    else $error("fast pwm did not restart at top");

  a_pc_top_hold: assert property (s_pc_at_top |=> s_pc_reversed)
    else $error("dual slope did not reverse after top");

  a_wrap_sticky: assert property (
    state_r.wrap_f && !(fwr && hwdata_i[timer_wave_pkg::FLAG_WRAP_BIT])
    |=> state_r.wrap_f)
    else $error("wrap flag lost without clear");

  a_match_block: assert property (
    cwr && !tick && !state_r.match_f_a
    |=> !state_r.match_f_a ##1 !state_r.match_f_a)
    else $error("match not blocked after count write");

  a_pin_drive: assert property (
    state_r.act_a != timer_wave_pkg::ACT_NONE
    |-> wave_out_a_o == state_r.wave_a && wave_out_a_oe_o == state_r.dir[0])
    else $error("pin a not following wave level");

  a_hold_none: assert property (
    state_r.act_b == timer_wave_pkg::ACT_NONE && !(state_r.dsel && state_r.dwr)
    |=> state_r.wave_b == $past(state_r.wave_b))
    else $error("wave b changed with no action");

endmodule : timer_waveform_modes

`default_nettype wire

/* tb/pin_model.sv */
// far-side model of the port pin that carries a wave output
// assumes level and enable come straight from the timer ports
`timescale 1ns/100ps
`default_nettype none
module pin_model
(
  input  wire logic oe_i,
  input  wire logic lvl_i,
  output logic      pin_o
);
  // a released pin rests at its pull-up level
  assign pin_o = oe_i ? lvl_i : 1'b1;
endmodule : pin_model
`default_nettype wire

/* tb/tb_top.sv */
// self-checking testbench for the waveform timer
// assumes the register map and zero-wait bus timing of the design
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        clk_i;
  logic        rst_n_i;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        wa, wa_oe, wb, wb_oe, fw, fa, fb, pin_a, pin_b;
  int          errors;
  int          cmp_count;
  int          cyc;
  logic [31:0] rd;

  timer_waveform_modes #(.PRESC_W(16)) uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(),
    .wave_out_a_o(wa), .wave_out_a_oe_o(wa_oe), .wave_out_b_o(wb),
    .wave_out_b_oe_o(wb_oe), .wrap_flag_o(fw), .match_flag_a_o(fa),
    .match_flag_b_o(fb));
  pin_model pa (.oe_i(wa_oe), .lvl_i(wa), .pin_o(pin_a));
  pin_model pb (.oe_i(wb_oe), .lvl_i(wb), .pin_o(pin_b));

  // ---------------------------------------------------------------
  // bus master and checking helpers
  // ---------------------------------------------------------------
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'h2;
    @(posedge clk_i);
    while (hready !== 1'b1) @(posedge clk_i);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    @(posedge clk_i);
    while (hready !== 1'b1) @(posedge clk_i);
    rd = hrdata;
  endtask : bus

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // pin must keep one level for n cycles
  task automatic hold(input logic e, input int n);
    logic bad;
    bad = 1'b0;
    repeat (n)
    begin
      @(posedge clk_i);
      if (pin_a !== e) bad = 1'b1;
    end
    chk({31'h0, bad}, 32'h0);
  endtask : hold

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_normal;
    bus(timer_wave_pkg::OFF_CTRL, 1'b1, 32'h0000_0000);
    bus(timer_wave_pkg::OFF_FLAGS, 1'b1, 32'h0000_0007);
    bus(timer_wave_pkg::OFF_COUNT, 1'b1, 32'h0000_00F0);
    bus(timer_wave_pkg::OFF_CTRL, 1'b1, 32'h0000_0100);
    repeat (8) @(posedge clk_i);
    chk({31'h0, fw}, 32'h0);
    repeat (20) @(posedge clk_i);
    chk({31'h0, fw}, 32'h1);
    bus(timer_wave_pkg::OFF_COUNT, 1'b0, 32'h0);
    chk({31'h0, rd[7:0] < 8'h20}, 32'h1);
    repeat (300) @(posedge clk_i);
    bus(timer_wave_pkg::OFF_FLAGS, 1'b0, 32'h0);
    chk(rd & 32'h1, 32'h1);
    $display("test normal done");
  endtask : t_normal

  // toggle output a and count its edges over a window
  task automatic t_tog(input logic [2:0] m, input logic [7:0] c, input int n,
                       input logic ew);
    int   tg;
    logic lst;
    bus(timer_wave_pkg::OFF_CMP_A, 1'b1, {24'h00_0000, c});
    bus(timer_wave_pkg::OFF_PIN, 1'b1, 32'h0000_0001);
    bus(timer_wave_pkg::OFF_CTRL, 1'b1, {23'h0, 1'b1, 4'h1, 1'b0, m});
    bus(timer_wave_pkg::OFF_COUNT, 1'b1, 32'h0000_0000);
    repeat (600) @(posedge clk_i);
    bus(timer_wave_pkg::OFF_FLAGS, 1'b1, 32'h0000_0007);
    tg  = 0;
    lst = pin_a;
    repeat (n)
    begin
      @(posedge clk_i);
      if (pin_a !== lst) tg++;
      lst = pin_a;
    end
    chk(tg, 10);
    chk({31'h0, fa}, 32'h1);
    chk({31'h0, fb}, 32'h1);
    chk({31'h0, fw}, {31'h0, ew});
    $display("test toggle mode %0d done", m);
  endtask : t_tog

  // constant level at an extreme compare value
  task automatic t_pwm(input logic [2:0] m, input logic [1:0] ac,
                       input logic [7:0] c, input logic e);
    bus(timer_wave_pkg::OFF_CMP_A, 1'b1, {24'h00_0000, c});
    bus(timer_wave_pkg::OFF_CTRL, 1'b1, {23'h0, 1'b1, 2'h0, ac, 1'b0, m});
    // dual slope loads the buffer at top, so the level may need two periods
    repeat (1100) @(posedge clk_i);
    hold(e, 520);
    bus(timer_wave_pkg::OFF_PIN, 1'b1, 32'h0000_0000);
    hold(1'b1, 4);
    chk({31'h0, pin_b}, 32'h1);
    bus(timer_wave_pkg::OFF_PIN, 1'b1, 32'h0000_0001);
    $display("test level mode %0d done", m);
  endtask : t_pwm

  // compare zero in fast pwm gives one spike per count period
  task automatic t_spike;
    int hi;
    bus(timer_wave_pkg::OFF_CMP_A, 1'b1, 32'h0000_0000);
    bus(timer_wave_pkg::OFF_CTRL, 1'b1, 32'h0000_0123);
    repeat (600) @(posedge clk_i);
    hi = 0;
    repeat (512)
    begin
      @(posedge clk_i);
      if (pin_a === 1'b1) hi++;
    end
    chk(hi, 2);
    $display("test spike done");
  endtask : t_spike

  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // clock and run-length guard
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      errors++;
      close_out();
    end
  end

  // main sequence
  initial
  begin
    hsel    = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'b00;
    hwrite  = 1'b0;
    hsize   = 3'h0;
    hwdata  = 32'h0;
    rst_n_i = 1'b0;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_normal();
    t_tog(timer_wave_pkg::MODE_CTC, 8'h05, 60, 1'b0);
    t_tog(timer_wave_pkg::MODE_FAST_A, 8'h09, 100, 1'b1);
    t_tog(timer_wave_pkg::MODE_PC_A, 8'h09, 180, 1'b1);
    t_pwm(timer_wave_pkg::MODE_FAST_FF, 2'h2, 8'hFF, 1'b1);
    t_pwm(timer_wave_pkg::MODE_FAST_FF, 2'h3, 8'hFF, 1'b0);
    t_pwm(timer_wave_pkg::MODE_PC_FF, 2'h2, 8'h00, 1'b0);
    t_pwm(timer_wave_pkg::MODE_PC_FF, 2'h2, 8'hFF, 1'b1);
    t_pwm(timer_wave_pkg::MODE_PC_FF, 2'h3, 8'h00, 1'b1);
    t_spike();
    close_out();
  end
endmodule : tb_top
`default_nettype wire
